// >>> rtl/prs_pkg.sv
// Constants, register map and carriers for the position regulator and
// step output stage. Assumes one 125 MHz clock shared by all users.
`default_nettype none

package prs_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] PRS_ADR_PGAIN  = 8'h20;
   localparam logic [7:0] PRS_ADR_IGAIN  = 8'h21;
   localparam logic [7:0] PRS_ADR_DGAIN  = 8'h22;
   localparam logic [7:0] PRS_ADR_ILIM   = 8'h23;
   localparam logic [7:0] PRS_ADR_ISUM   = 8'h24;
   localparam logic [7:0] PRS_ADR_DDIV   = 8'h25;
   localparam logic [7:0] PRS_ADR_DVLIM  = 8'h27;
   localparam logic [7:0] PRS_ADR_ERR    = 8'h28;
   localparam logic [7:0] PRS_ADR_RVEL   = 8'h29;
   localparam logic [7:0] PRS_ADR_DBAND  = 8'h2A;
   localparam logic [7:0] PRS_ADR_HSTHR  = 8'h30;
   localparam logic [7:0] PRS_ADR_XDIV   = 8'h31;
   localparam logic [7:0] PRS_ADR_DMODE  = 8'h32;
   localparam logic [7:0] PRS_ADR_TPTR   = 8'h33;
   localparam logic [7:0] PRS_ADR_IDLE   = 8'h34;
   localparam logic [7:0] PRS_ADR_PWID   = 8'h35;

   // ****************************************
   // Field layout, reset values, timing
   // ****************************************
   localparam int          PRS_DVLIM_LOW   = 8;
   localparam int          PRS_HSTHR_LOW   = 21;
   localparam logic [15:0] PRS_XDIV_RST    = 16'h0010;
   localparam logic [6:0]  PRS_TICK_LAST   = 7'h7F;
   localparam int          PRS_GAIN_SHIFT  = 8;
   localparam int          PRS_ILIM_SHIFT  = 16;
   localparam logic signed [63:0] PRS_MAX31 = 64'sh0000_0000_7FFF_FFFF;
   localparam logic signed [63:0] PRS_MAX23 = 64'sh0000_0000_007F_FFFF;
   localparam logic signed [63:0] PRS_DMAX  = 64'sh0000_0000_0000_007F;
   localparam logic [1:0]  PRS_XLAG_RST    = 2'h0;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } prs_req_s;

   typedef struct packed {
      logic step;
      logic xstep;
      logic dir;
   } prs_pins_s;

endpackage

`default_nettype wire

// >>> rtl/prs_regulator.sv
// Position regulator and step/direction output stage.
// Assumes register requests, positions and step requests come from logic
// on the same clock, so nothing here is synchronised.
`default_nettype none

module prs_regulator
   import prs_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic           rstn_i,
   input  wire prs_req_s       req_i,
   output logic        [31:0]  rdata_o,
   input  wire logic   [31:0]  enc_pos_i,
   input  wire logic   [31:0]  ramp_pos_i,
   input  wire logic   [31:0]  ramp_vel_i,
   input  wire logic           exact_hit_i,
   input  wire logic           pid_base_i,
   input  wire logic           step_req_i,
   input  wire logic           dir_req_i,
   output logic                step_ready_o,
   output logic        [31:0]  reg_vel_o,
   output logic                high_speed_indicator_o,
   output logic                standby_o,
   output prs_pins_s           pins_o
);

   function automatic logic signed [63:0] clip_f(
      input logic signed [63:0] v,
      input logic signed [63:0] lim);
      logic signed [63:0] r;
      r = v;
      if (v > lim)
         r = lim;
      else if (v < -lim)
         r = -lim;
      return r;
   endfunction

   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_PULSE} prs_step_e;

   // ****************************************
   // Register file
   // ****************************************
   logic        [23:0] pgain_reg, igain_reg, dgain_reg;
   logic        [14:0] ilim_reg;
   logic        [7:0]  ddiv_reg;
   logic        [30:0] dvlim_reg;
   logic        [19:0] dband_reg;
   logic        [28:0] hsthr_reg;
   logic        [15:0] xdiv_reg;
   logic               dmode_reg;
   logic        [12:0] tptr_reg;
   logic        [11:0] idle_reg;
   logic        [7:0]  pwid_reg;

   wire wr_cfg  = req_i.wr;
   wire wr_isum = req_i.wr && (req_i.addr == PRS_ADR_ISUM);
   wire wr_tptr = req_i.wr && (req_i.addr == PRS_ADR_TPTR);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pgain_reg <= '0;
         igain_reg <= '0;
         dgain_reg <= '0;
         ilim_reg  <= '0;
         ddiv_reg  <= '0;
         dvlim_reg <= '0;
         dband_reg <= '0;
         hsthr_reg <= '0;
         xdiv_reg  <= PRS_XDIV_RST;
         dmode_reg <= 1'b0;
         idle_reg  <= '0;
         pwid_reg  <= '0;
      end else if (wr_cfg) begin
         case (req_i.addr)
            PRS_ADR_PGAIN: pgain_reg <= req_i.wdata[23:0];
            PRS_ADR_IGAIN: igain_reg <= req_i.wdata[23:0];
            PRS_ADR_DGAIN: dgain_reg <= req_i.wdata[23:0];
            PRS_ADR_ILIM:  ilim_reg  <= req_i.wdata[14:0];
            PRS_ADR_DDIV:  ddiv_reg  <= req_i.wdata[7:0];
            PRS_ADR_DVLIM: dvlim_reg <= {req_i.wdata[30:PRS_DVLIM_LOW],
                                         8'h00};
            PRS_ADR_DBAND: dband_reg <= req_i.wdata[19:0];
            PRS_ADR_HSTHR: hsthr_reg <= {req_i.wdata[28:PRS_HSTHR_LOW],
                                         21'h000000};
            PRS_ADR_XDIV:  xdiv_reg  <= req_i.wdata[15:0];
            PRS_ADR_DMODE: dmode_reg <= req_i.wdata[0];
            PRS_ADR_IDLE:  idle_reg  <= req_i.wdata[11:0];
            PRS_ADR_PWID:  pwid_reg  <= req_i.wdata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Regulator timing
   // ****************************************
   logic        [6:0]  tick_reg;
   logic        [7:0]  dcnt_reg;
   wire tick  = (tick_reg == PRS_TICK_LAST);
   wire dtick = tick && (dcnt_reg >= ddiv_reg - 8'h01);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_reg <= '0;
         dcnt_reg <= '0;
      end else begin
         tick_reg <= tick_reg + 7'h01;
         if (dtick)
            dcnt_reg <= '0;
         else if (tick)
            dcnt_reg <= dcnt_reg + 8'h01;
      end
   end

   // ****************************************
   // Error, deadband and terms
   // ****************************************
   logic signed [23:0] err_reg, dlast_reg;
   logic signed [31:0] isum_reg, pterm_reg, iterm_reg, dterm_reg;
   logic               hit_reg;

   wire signed [63:0] err_raw = 64'($signed(enc_pos_i))
                               - 64'($signed(ramp_pos_i));
   wire signed [63:0] err_cl  = clip_f(err_raw, PRS_MAX23);
   wire        [23:0] err_abs = err_reg[23] ? 24'(-err_reg)
                                            : 24'(err_reg);
   wire               in_band = err_abs < {4'h0, dband_reg};
   wire               hold    = hit_reg && in_band;
   wire signed [63:0] e64     = hold ? 64'sh0 : 64'(err_reg);

   wire signed [63:0] p_prod  = e64 * $signed(64'(pgain_reg));
   wire signed [63:0] p_next  = clip_f(p_prod >>> PRS_GAIN_SHIFT,
                                       PRS_MAX31);
   wire signed [63:0] ilim    = $signed(64'({ilim_reg, 16'h0000}));
   wire signed [63:0] isum_nx = clip_f(64'(isum_reg) + e64, ilim);
   wire signed [63:0] i_prod  = (64'(isum_reg) >>> PRS_GAIN_SHIFT)
                               * $signed(64'(igain_reg));
   wire signed [63:0] i_next  = clip_f(i_prod >>> PRS_GAIN_SHIFT,
                                       PRS_MAX31);
   wire signed [63:0] d_delta = clip_f(64'(dlast_reg) - e64, PRS_DMAX);
   wire signed [63:0] d_next  = d_delta * $signed(64'(dgain_reg));

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         err_reg   <= '0;
         dlast_reg <= '0;
         hit_reg   <= 1'b0;
         pterm_reg <= '0;
         iterm_reg <= '0;
         dterm_reg <= '0;
      end else begin
         err_reg <= err_cl[23:0];
         if (exact_hit_i)
            hit_reg <= 1'b1;
         else if (!in_band)
            hit_reg <= 1'b0;
         if (tick) begin
            pterm_reg <= p_next[31:0];
            iterm_reg <= i_next[31:0];
         end
         if (dtick) begin
            dterm_reg <= d_next[31:0];
            dlast_reg <= e64[23:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         isum_reg <= '0;
      else if (wr_isum || hold)
         isum_reg <= '0;
      else if (tick)
         isum_reg <= isum_nx[31:0];
   end

   // ****************************************
   // Correction and outputs
   // ****************************************
   // sum of three terms
   wire signed [63:0] pid_sum = 64'(pterm_reg) + 64'(iterm_reg)
                               + 64'(dterm_reg);
   wire signed [63:0] corr    = (dvlim_reg == '0) ? 64'sh0
                               : clip_f(pid_sum, 64'(dvlim_reg));
   wire signed [63:0] vel64   = 64'($signed(ramp_vel_i));
   wire signed [63:0] rvel_nx = clip_f(vel64 + corr, PRS_MAX31);
   wire signed [63:0] mon_nx  = clip_f(pid_base_i ? pid_sum + vel64
                                                  : pid_sum, PRS_MAX31);
   logic        [31:0] mon_reg;
   logic               hs_reg;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_vel_o <= '0;
         mon_reg   <= '0;
         hs_reg    <= 1'b0;
      end else begin
         reg_vel_o <= rvel_nx[31:0];
         mon_reg   <= mon_nx[31:0];
         hs_reg    <= $signed(ramp_vel_i) >= $signed({3'b000, hsthr_reg});
      end
   end
   assign high_speed_indicator_o = hs_reg;

   // ****************************************
   // Step sequencer
   // ****************************************
   prs_step_e          st_reg;
   logic        [7:0]  cnt_reg, xw_reg;
   logic        [15:0] xcnt_reg, pre_reg;
   logic        [1:0]  xlag_reg;
   logic        [11:0] sb_reg;
   logic               dir_reg;

   wire [7:0]  pw_eff  = (pwid_reg == '0) ? 8'h01 : pwid_reg;
   wire [15:0] xd_eff  = (xdiv_reg == '0) ? 16'h0001 : xdiv_reg;
   wire        idle    = (st_reg == ST_IDLE);
   wire        take    = idle && step_req_i;
   wire        turn    = take && (dir_req_i != dir_reg);
   wire        go_now  = take && !(turn && dmode_reg);
   wire        go_dly  = (st_reg == ST_DELAY) && (cnt_reg == '0);
   wire        pulse_go = go_now || go_dly;
   wire        xwrap   = (xcnt_reg >= xd_eff - 16'h0001);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg  <= ST_IDLE;
         cnt_reg <= '0;
         dir_reg <= 1'b0;
      end else begin
         case (st_reg)
            ST_IDLE: begin
               if (turn)
                  dir_reg <= dir_req_i;
               if (go_now) begin
                  st_reg  <= ST_PULSE;
                  cnt_reg <= pw_eff - 8'h01;
               end else if (take) begin
                  st_reg  <= ST_DELAY;
                  cnt_reg <= pw_eff - 8'h01;
               end
            end
            ST_DELAY: begin
               cnt_reg <= go_dly ? pw_eff - 8'h01 : cnt_reg - 8'h01;
               if (go_dly)
                  st_reg <= ST_PULSE;
            end
            ST_PULSE: begin
               if (cnt_reg == '0)
                  st_reg <= ST_IDLE;
               else
                  cnt_reg <= cnt_reg - 8'h01;
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // Extra step, table pointer and idle wait share the step start
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         xcnt_reg <= '0;
         xlag_reg <= PRS_XLAG_RST;
         xw_reg   <= '0;
         tptr_reg <= '0;
         pre_reg  <= '0;
         sb_reg   <= '0;
      end else begin
         if (pulse_go)
            xcnt_reg <= xwrap ? 16'h0000 : xcnt_reg + 16'h0001;
         xlag_reg <= {xlag_reg[0], pulse_go && xwrap};
         if (xlag_reg[1])
            xw_reg <= pw_eff;
         else if (xw_reg != '0)
            xw_reg <= xw_reg - 8'h01;
         if (wr_tptr)
            tptr_reg <= req_i.wdata[12:0];
         else if (pulse_go)
            tptr_reg <= (idle ? dir_req_i : dir_reg) ? tptr_reg - 13'h0001
                                                     : tptr_reg + 13'h0001;
         if (pulse_go) begin
            pre_reg <= '0;
            sb_reg  <= '0;
         end else if (sb_reg != idle_reg) begin
            pre_reg <= pre_reg + 16'h0001;
            if (pre_reg == 16'hFFFF)
               sb_reg <= sb_reg + 12'h001;
         end
      end
   end

   assign pins_o.step   = (st_reg == ST_PULSE);
   assign pins_o.xstep  = (xw_reg != '0);
   assign pins_o.dir    = dir_reg;
   assign step_ready_o  = idle;
   assign standby_o     = (sb_reg == idle_reg) && idle;

   // ****************************************
   // Read path
   // ****************************************
   always_comb begin
      case (req_i.addr)
         PRS_ADR_ISUM: rdata_o = isum_reg;
         PRS_ADR_ERR:  rdata_o = 32'($signed(err_reg));
         PRS_ADR_RVEL: rdata_o = mon_reg;
         PRS_ADR_TPTR: rdata_o = {19'h00000, tptr_reg};
         default:      rdata_o = 32'h0000_0000;
      endcase
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [8:0] hi_cnt;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         hi_cnt <= '0;
      else
         hi_cnt <= pins_o.step ? hi_cnt + 9'h001 : 9'h000;
   end

   isum_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_isum |=> isum_reg == 32'h0) else $error("isum not cleared");
   isum_window_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      tick && !wr_isum && !hold
      |=> 64'(isum_reg) <= $past(ilim) && 64'(isum_reg) >= -$past(ilim))
      else $error("isum above limit");
   err_range_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      64'(err_reg) <= PRS_MAX23 && 64'(err_reg) >= -PRS_MAX23)
      else $error("error out of range");
   band_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      hold && !wr_isum |=> isum_reg == 32'h0) else $error("band not held");
   speed_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $signed(ramp_vel_i) < $signed({3'b000, hsthr_reg})
      |=> !high_speed_indicator_o) else $error("speed flag wrong");
   step_width_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $fell(pins_o.step) |-> hi_cnt == {1'b0, pw_eff})
      else $error("step width wrong");
   dir_steady_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      pins_o.step && $past(pins_o.step) |-> $stable(pins_o.dir))
      else $error("dir moved in step");
   xstep_lag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(pins_o.xstep) |-> $past(pulse_go, 3) && $past(xwrap, 3))
      else $error("extra step lag wrong");
   turn_wait_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      turn && dmode_reg |=> !pins_o.step ##1 (!pins_o.step || pw_eff == 8'h01))
      else $error("no delay on turn");

endmodule // prs_regulator

`default_nettype wire

// >>> testbench/prs_drive_model.sv
// Model of the external step/direction drive; measures what it sees.
// Assumes the pins come from flops on the same clock.
`default_nettype none

module prs_drive_model
   import prs_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire prs_pins_s   pins_i,
   output logic      [31:0] steps_o,
   output logic      [31:0] xsteps_o,
   output logic      [31:0] width_o,
   output logic      [31:0] xlag_o,
   output logic      [31:0] gap_o,
   output logic      [31:0] bad_dir_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic        step_q;
   logic        xstep_q;
   logic        dir_q;
   logic [31:0] cyc;
   logic [31:0] rise_t;
   logic [31:0] dir_t;
   logic [31:0] wcnt;

   // ****************************************
   // Pulse measurement
   // ****************************************
   // Drive latches on the step rise, so dir must settle before it
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {step_q, xstep_q, dir_q} <= 3'h0;
         {cyc, rise_t, dir_t, wcnt} <= '0;
         {steps_o, xsteps_o, width_o} <= '0;
         {xlag_o, gap_o, bad_dir_o} <= '0;
      end else begin
         cyc <= cyc + 32'h1;
         step_q <= pins_i.step;
         xstep_q <= pins_i.xstep;
         dir_q <= pins_i.dir;
         if (pins_i.step)
            wcnt <= wcnt + 32'h1;
         if (pins_i.step && !step_q) begin
            steps_o <= steps_o + 32'h1;
            rise_t <= cyc;
            wcnt <= 32'h1;
            gap_o <= (pins_i.dir != dir_q) ? 32'h0 : cyc - dir_t;
         end
         if (!pins_i.step && step_q)
            width_o <= wcnt;
         if (pins_i.xstep && !xstep_q) begin
            xsteps_o <= xsteps_o + 32'h1;
            xlag_o <= cyc - rise_t;
         end
         if (pins_i.dir != dir_q) begin
            dir_t <= cyc;
            if (step_q && pins_i.step)
               bad_dir_o <= bad_dir_o + 32'h1;
         end
      end
   end

endmodule // prs_drive_model

`default_nettype wire

// >>> testbench/tb_pid_regulator_step_output.sv
// Self-checking bench for the position regulator and step output.
// Assumes the package, the design and the drive model compile first.
`default_nettype none

module tb_pid_regulator_step_output
   import prs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_i;
   logic        rstn_i;
   prs_req_s    req;
   logic [31:0] rdata;
   logic [31:0] enc;
   logic [31:0] rpos;
   logic [31:0] rvel;
   logic        hit;
   logic        base;
   logic        sreq;
   logic        sdir;
   logic        ready;
   logic [31:0] vel_o;
   logic        hsi;
   logic        stby;
   prs_pins_s   pins;
   logic [31:0] steps;
   logic [31:0] xsteps;
   logic [31:0] width;
   logic [31:0] xlag;
   logic [31:0] gap;
   logic [31:0] bad_dir;
   int          err_total;
   int          checks;
   int          cyc;
   int          n;

   prs_regulator dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req),
      .rdata_o(rdata), .enc_pos_i(enc), .ramp_pos_i(rpos),
      .ramp_vel_i(rvel), .exact_hit_i(hit), .pid_base_i(base),
      .step_req_i(sreq), .dir_req_i(sdir), .step_ready_o(ready),
      .reg_vel_o(vel_o), .high_speed_indicator_o(hsi),
      .standby_o(stby), .pins_o(pins));

   prs_drive_model drv_u (.clk_i(clk_i), .rstn_i(rstn_i), .pins_i(pins),
      .steps_o(steps), .xsteps_o(xsteps), .width_o(width),
      .xlag_o(xlag), .gap_o(gap), .bad_dir_o(bad_dir));

   // ****************************************
   // Clock, timeout, verdict
   // ****************************************
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Standby wait alone needs about 65536 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk_i);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk_i);
      req.wr = 1'b0;
   endtask

   // Reads are combinational, so sample once the address settles
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input string what);
      @(negedge clk_i);
      req.addr = a;
      @(negedge clk_i);
      chk(what, rdata, exp);
   endtask

   task automatic wt(input int c);
      repeat (c) @(negedge clk_i);
   endtask

   task automatic step(input logic d);
      int k;
      k = 0;
      @(negedge clk_i);
      while (ready !== 1'b1 && k < 200) begin
         @(negedge clk_i);
         k++;
      end
      sreq = 1'b1;
      sdir = d;
      @(negedge clk_i);
      sreq = 1'b0;
      chk("busy ready", {31'h0, ready}, 32'h0);
      wt(12);
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rstn_i = 1'b0;
      req = '0;
      {enc, rpos, rvel} = '0;
      {hit, base, sreq, sdir} = 4'h0;
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      rstn_i = 1'b1;
      rd(PRS_ADR_ISUM, 32'h0, "isum reset");
      rd(8'h26, 32'h0, "unmapped");
      rd(PRS_ADR_XDIV, 32'h0, "write only");
      chk("standby idle 0", {31'h0, stby}, 32'h1);
      wr(PRS_ADR_TPTR, 32'hFFFF_FFFF);
      rd(PRS_ADR_TPTR, 32'h0000_1FFF, "pointer");
      enc = 32'h64;
      rpos = 32'h28;
      wt(2);
      rd(PRS_ADR_ERR, 32'h3C, "error");
      enc = 32'h0100_0000;
      wt(2);
      rd(PRS_ADR_ERR, 32'h007F_FFFF, "error clip");
      enc = 32'h64;
      rvel = 32'h3E8;
      wr(PRS_ADR_PGAIN, 32'h100);
      wr(PRS_ADR_DVLIM, 32'h100);
      wt(260);
      rd(PRS_ADR_RVEL, 32'h3C, "p result");
      chk("vel", vel_o, 32'h424);
      base = 1'b1;
      rd(PRS_ADR_RVEL, 32'h424, "base one");
      wr(PRS_ADR_PGAIN, 32'hA00);
      wt(260);
      chk("vel clip", vel_o, 32'h4E8);
      wr(PRS_ADR_DVLIM, 32'h0);
      wt(3);
      chk("vel off", vel_o, 32'h3E8);
      base = 1'b0;
      wr(PRS_ADR_PGAIN, 32'h0);
      wt(260);
      rd(PRS_ADR_RVEL, 32'h0, "p off");
      wr(PRS_ADR_ILIM, 32'h1);
      enc = 32'h0100_0000;
      wt(400);
      rd(PRS_ADR_ISUM, 32'h0001_0000, "isum clip");
      // Zero error, so no tick can refill the sum before the read
      enc = 32'h28;
      wt(2);
      wr(PRS_ADR_ISUM, 32'h1234);
      rd(PRS_ADR_ISUM, 32'h0, "isum clear");
      // Deadband entered after a hit, then left again
      enc = 32'h64;
      wr(PRS_ADR_PGAIN, 32'h100);
      wr(PRS_ADR_DBAND, 32'h100);
      wt(2);
      hit = 1'b1;
      wt(1);
      hit = 1'b0;
      wt(400);
      rd(PRS_ADR_RVEL, 32'h0, "band result");
      rd(PRS_ADR_ISUM, 32'h0, "band isum");
      enc = 32'h1000;
      wt(260);
      rd(PRS_ADR_RVEL, 32'hFD8, "band left");
      enc = 32'h0100_0000;
      wr(PRS_ADR_PGAIN, 32'h0);
      wr(PRS_ADR_IGAIN, 32'h100);
      wt(400);
      rd(PRS_ADR_RVEL, 32'h100, "i result");
      // Error step of more than 127 gives one clipped D pulse
      wr(PRS_ADR_IGAIN, 32'h0);
      wr(PRS_ADR_DGAIN, 32'h2);
      wr(PRS_ADR_DDIV, 32'h2);
      wt(600);
      enc = 32'h38;
      req.addr = PRS_ADR_RVEL;
      n = 0;
      @(negedge clk_i);
      while (rdata === 32'h0 && n < 700) begin
         @(negedge clk_i);
         n++;
      end
      chk("d result", rdata, 32'h0000_00FE);
      n = 0;
      while (rdata === 32'h0000_00FE && n < 300) begin
         @(negedge clk_i);
         n++;
      end
      chk("d period", n, 32'h0000_0100);
      wr(PRS_ADR_HSTHR, 32'h0020_0000);
      rvel = 32'h0020_0000;
      wt(2);
      chk("fast", {31'h0, hsi}, 32'h1);
      rvel = 32'h001F_FFFF;
      wt(2);
      chk("slow", {31'h0, hsi}, 32'h0);
      wr(PRS_ADR_PWID, 32'h3);
      wr(PRS_ADR_XDIV, 32'h2);
      wr(PRS_ADR_DMODE, 32'h0);
      wr(PRS_ADR_TPTR, 32'h0);
      for (int i = 0; i < 4; i++)
         step(1'b0);
      chk("width", width, 32'h3);
      chk("steps", steps, 32'h4);
      chk("xsteps", xsteps, 32'h2);
      chk("xlag", xlag, 32'h2);
      rd(PRS_ADR_TPTR, 32'h4, "pointer up");
      wr(PRS_ADR_DMODE, 32'h1);
      step(1'b1);
      chk("turn delay", {31'h0, gap >= 32'h3}, 32'h1);
      wr(PRS_ADR_DMODE, 32'h0);
      step(1'b0);
      chk("no delay", {31'h0, gap < 32'h3}, 32'h1);
      chk("dir steady", bad_dir, 32'h0);
      rd(PRS_ADR_TPTR, 32'h4, "pointer back");
      wr(PRS_ADR_IDLE, 32'h1);
      step(1'b0);
      chk("busy", {31'h0, stby}, 32'h0);
      n = 0;
      while (stby !== 1'b1 && n < 70000) begin
         @(negedge clk_i);
         n++;
      end
      chk("idle wait", {31'h0, n > 65500 && n < 65540}, 32'h1);
      give_verdict();
   end

endmodule // tb_pid_regulator_step_output

`default_nettype wire
